// ### rtl/umbc_pkg.sv
// package for the serial port mode, status and baud configuration block
// assumes: 8-bit register port, main clock at 10 MHz
package umbc_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_MODE   = 16'hFFA0;
  localparam logic [15:0] ADDR_STATUS = 16'hFFA1;
  localparam logic [15:0] ADDR_BAUD   = 16'hFFA2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET   = 8'h00;

  // ---------------------------------------------------------------
  // mode register fields
  // ---------------------------------------------------------------
  localparam int MODE_TX_ON    = 7;
  localparam int MODE_RX_ON    = 6;
  localparam int MODE_PAR_HI   = 5;
  localparam int MODE_PAR_LO   = 4;
  localparam int MODE_CHAR_LEN = 3;
  localparam int MODE_STOP_LEN = 2;
  localparam int MODE_ERR_SUPP = 1;
  localparam logic [7:0] MODE_WMASK = 8'hFE;

  // ---------------------------------------------------------------
  // status register fields
  // ---------------------------------------------------------------
  localparam int STAT_PARITY  = 2;
  localparam int STAT_FRAMING = 1;
  localparam int STAT_OVERRUN = 0;

  // ---------------------------------------------------------------
  // baud register fields
  // ---------------------------------------------------------------
  localparam int BAUD_PRE_LSB = 4;
  localparam int BAUD_PRE_MSB = 6;
  localparam int BAUD_DIV_MSB = 3;
  localparam logic [7:0] BAUD_WMASK = 8'h7F;
  localparam logic [3:0] DIV_PROHIBITED = 4'hF;
  localparam logic [4:0] DIV_BASE = 5'h10;

  // ---------------------------------------------------------------
  // parity modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } umbc_parity_e;

  // ---------------------------------------------------------------
  // receive buffer
  // ---------------------------------------------------------------
  localparam int BUF_DEPTH = 2;

endpackage

// ### rtl/umbc_uart_cfg.sv
// mode, receive error status and baud generator of the async serial port
// assumes: shift/sample datapath outside, software reaches the registers
//   through a byte port with optional single-bit writes to the mode register
//
// Functional notes
// - tx/rx enable bits give pins serial function; each pin has port use while its own bit is clear.
// - both directions run independently, full duplex, one character per start bit.
// - parity field 00 none, 01 zero unchecked, 10 odd, 11 even.
// - length bit picks 7 or 8 data bits; stop bit picks one or two.
// - receiver checks only the first stop bit of a frame.
// - error suppress bit stops receive-done event on frames with errors.
// - mode register byte or bit writable, bit 0 reads zero, resets to zero.
// - status register read only, resets zero, bits 7 to 3 read zero.
// - parity error flag set on odd/even parity mismatch.
// - framing error flag set when the stop bit reads low.
// - overrun flag set when a frame ends before the buffer was read.
// - overrun repeats on every frame until software reads the buffer.
// - baud register written whole, resets zero, bit 7 reads zero.
// - prescaler gives main clock divided by two to the power code plus one.
// - divisor divides the prescaled clock by 16 plus code; all ones prohibited.
// - baud rate is main clock over 2^(n+2) times (k+16).
`timescale 1ns/1ps
`default_nettype none

module umbc_uart_cfg (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // register port
  input  wire logic [15:0] regAddr,
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regBitWrEn,
  input  wire logic [2:0]  regBitSel,
  input  wire logic        regBitVal,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData,
  // frame settings to the datapath
  output logic             txPathOn,
  output logic             rxPathOn,
  output logic      [1:0]  parityMode,
  output logic             charLen8,
  output logic             stopLen2,
  // baud timing to the datapath
  output logic             sampleTick,
  output logic             baudTick,
  // received frame from the datapath
  input  wire logic        rxFrameValid,
  output logic             rxFrameReady,
  input  wire logic [7:0]  rxFrameData,
  input  wire logic        rxFrameParity,
  input  wire logic        rxFrameStop,
  // characters towards the holding buffer
  output logic             rxCharValid,
  input  wire logic        rxCharReady,
  output logic      [7:0]  rxCharData,
  input  wire logic        rxBufRead,
  output logic             rxDoneEvent,
  // pins and port function
  input  wire logic        serialInPin,
  output logic             rxSerialIn,
  output logic             portInRx,
  input  wire logic        txSerialOut,
  input  wire logic        portOutVal,
  input  wire logic        portOutOe,
  output logic             serialOutPin,
  output logic             serialOutPinOe
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic onesOdd(input logic [7:0] d, input logic len8, input logic p);
    logic [7:0] m;
    m = len8 ? d : {1'b0, d[6:0]};
    return ^{m, p};
  endfunction

  function automatic logic [7:0] preMask(input logic [2:0] code);
    logic [8:0] full;
    full = 9'h002 << code;
    return full[7:0] - 8'h01;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] modeReg_r;
  logic [7:0] statReg_r;
  logic [7:0] baudReg_r;
  logic       wrMode;
  logic       wrBaud;

  assign wrMode = ce && regWrEn && (regAddr == umbc_pkg::ADDR_MODE);
  assign wrBaud = ce && regWrEn && (regAddr == umbc_pkg::ADDR_BAUD);

  // mode register: byte or single-bit write, bit 0 held at zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      modeReg_r <= umbc_pkg::MODE_RESET;
    else if (wrMode)
      modeReg_r <= regWrData & umbc_pkg::MODE_WMASK;
    else if (ce && regBitWrEn && (regAddr == umbc_pkg::ADDR_MODE) && (regBitSel != 3'h0))
      modeReg_r[regBitSel] <= regBitVal;
  end

  // baud register: whole-byte write only, bit 7 held at zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      baudReg_r <= umbc_pkg::BAUD_RESET;
    else if (wrBaud)
      baudReg_r <= regWrData & umbc_pkg::BAUD_WMASK;
  end

  // read port: one cycle latency, unmapped addresses read zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      regRdData <= 8'h00;
    else if (ce && regRdEn)
    begin
      case (regAddr)
        umbc_pkg::ADDR_MODE:   regRdData <= modeReg_r;
        umbc_pkg::ADDR_STATUS: regRdData <= statReg_r;
        umbc_pkg::ADDR_BAUD:   regRdData <= baudReg_r;
        default:               regRdData <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // frame settings
  // ---------------------------------------------------------------
  logic txOn;
  logic rxOn;

  assign txOn = modeReg_r[umbc_pkg::MODE_TX_ON];
  assign rxOn = modeReg_r[umbc_pkg::MODE_RX_ON];

  // both directions are driven independently for full duplex
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      txPathOn   <= 1'b0;
      rxPathOn   <= 1'b0;
      parityMode <= umbc_pkg::PAR_NONE;
      charLen8   <= 1'b0;
      stopLen2   <= 1'b0;
    end
    else if (ce)
    begin
      txPathOn   <= txOn;
      rxPathOn   <= rxOn;
      parityMode <= modeReg_r[umbc_pkg::MODE_PAR_HI:umbc_pkg::MODE_PAR_LO];
      charLen8   <= modeReg_r[umbc_pkg::MODE_CHAR_LEN];
      stopLen2   <= modeReg_r[umbc_pkg::MODE_STOP_LEN];
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  logic rxPinMeta_r;
  logic rxPinSync_r;
  // pin goes to the serial path only in the enabled direction
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rxPinMeta_r    <= 1'b1;
      rxPinSync_r    <= 1'b1;
      rxSerialIn     <= 1'b1;
      portInRx       <= 1'b1;
      serialOutPin   <= 1'b1;
      serialOutPinOe <= 1'b0;
    end
    else if (ce)
    begin
      rxPinMeta_r    <= serialInPin;
      rxPinSync_r    <= rxPinMeta_r;
      rxSerialIn     <= rxOn ? rxPinSync_r : 1'b1;
      portInRx       <= rxPinSync_r;
      serialOutPin   <= txOn ? txSerialOut : portOutVal;
      serialOutPinOe <= txOn ? 1'b1 : portOutOe;
    end
  end

  // ---------------------------------------------------------------
  // baud generator
  // ---------------------------------------------------------------
  logic [7:0] preCnt_r;
  logic [4:0] divCnt_r;
  logic       phase_r;
  logic       genRun;
  logic       srcTick;
  logic       divEnd;
  logic [4:0] divLast;
  assign genRun  = (txOn || rxOn) && (baudReg_r[umbc_pkg::BAUD_DIV_MSB:0] != umbc_pkg::DIV_PROHIBITED);
  assign srcTick = genRun && (preCnt_r == preMask(baudReg_r[umbc_pkg::BAUD_PRE_MSB:umbc_pkg::BAUD_PRE_LSB]));
  assign divLast = umbc_pkg::DIV_BASE + {1'b0, baudReg_r[umbc_pkg::BAUD_DIV_MSB:0]} - 5'h01;
  assign divEnd  = srcTick && (divCnt_r == divLast);
  // prescaler: period 2^(code+1) main clocks
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      preCnt_r <= 8'h00;
    else if (ce)
    begin
      if (!genRun || srcTick || wrBaud)
        preCnt_r <= 8'h00;
      else
        preCnt_r <= preCnt_r + 8'h01;
    end
  end
  // divisor: 16+k source ticks, then a half-rate phase gives the bit period
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      divCnt_r   <= 5'h00;
      phase_r    <= 1'b0;
      sampleTick <= 1'b0;
      baudTick   <= 1'b0;
    end
    else if (ce)
    begin
      sampleTick <= divEnd;
      baudTick   <= divEnd && phase_r;
      if (!genRun || wrBaud)
      begin
        divCnt_r <= 5'h00;
        phase_r  <= 1'b0;
      end
      else if (divEnd)
      begin
        divCnt_r <= 5'h00;
        phase_r  <= ~phase_r;
      end
      else if (srcTick)
        divCnt_r <= divCnt_r + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // receive frame checks
  // ---------------------------------------------------------------
  logic frameTake;
  logic parErr;
  logic frmErr;
  logic ovrErr;
  logic unread_r;
  logic anyErr;
  assign frameTake = ce && rxOn && rxFrameValid && rxFrameReady;
  // odd mode fails on an even total of ones, even mode on an odd total
  assign parErr = modeReg_r[umbc_pkg::MODE_PAR_HI] &&
                  (onesOdd(rxFrameData, modeReg_r[umbc_pkg::MODE_CHAR_LEN], rxFrameParity) ==
                   modeReg_r[umbc_pkg::MODE_PAR_LO]);
  assign frmErr = !rxFrameStop;
  assign ovrErr = unread_r;
  assign anyErr = parErr || frmErr || ovrErr;
  // flags refreshed at each frame end; upper bits stay zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      statReg_r <= umbc_pkg::STATUS_RESET;
    else if (frameTake)
    begin
      statReg_r <= 8'h00;
      statReg_r[umbc_pkg::STAT_PARITY]  <= parErr;
      statReg_r[umbc_pkg::STAT_FRAMING] <= frmErr;
      statReg_r[umbc_pkg::STAT_OVERRUN] <= ovrErr;
    end
  end

  // unread marker: a new character wins over a read in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      unread_r <= 1'b0;
    else if (frameTake)
      unread_r <= 1'b1;
    else if (ce && rxBufRead)
      unread_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rxDoneEvent <= 1'b0;
    else if (ce)
      rxDoneEvent <= frameTake && !(anyErr && modeReg_r[umbc_pkg::MODE_ERR_SUPP]);
  end

  // ---------------------------------------------------------------
  // two-entry character buffer
  // ---------------------------------------------------------------
  logic [7:0] buf_r [0:umbc_pkg::BUF_DEPTH-1];
  logic [1:0] cnt_r;
  logic [1:0] cntNxt;
  logic       push;
  logic       pop;

  // a character that overran the holding buffer is dropped
  assign push = frameTake && !ovrErr;
  assign pop  = ce && rxCharValid && rxCharReady;

  always_comb
  begin
    cntNxt = cnt_r;
    if (push && !pop)
      cntNxt = cnt_r + 2'h1;
    else if (pop && !push)
      cntNxt = cnt_r - 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_r        <= 2'h0;
      rxCharValid  <= 1'b0;
      rxFrameReady <= 1'b1;
    end
    else if (ce)
    begin
      cnt_r        <= cntNxt;
      rxCharValid  <= (cntNxt != 2'h0);
      rxFrameReady <= (cntNxt != 2'h2);
    end
  end

  // head entry is always slot 0; a pop shifts slot 1 forward
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      buf_r[0] <= 8'h00;
      buf_r[1] <= 8'h00;
    end
    else if (ce)
    begin
      if (pop)
      begin
        buf_r[0] <= (push && (cnt_r == 2'h1)) ? rxFrameData : buf_r[1];
        if (push && (cnt_r == 2'h2))
          buf_r[1] <= rxFrameData;
      end
      else if (push)
      begin
        if (cnt_r == 2'h0)
          buf_r[0] <= rxFrameData;
        else
          buf_r[1] <= rxFrameData;
      end
    end
  end

  assign rxCharData = buf_r[0];

endmodule

`default_nettype wire

// ### test/umbc_far_end.sv
// far-end model: hands over finished frames and takes characters
// assumes: same clock as the block, one frame offered at a time
`timescale 1ns/1ps
`default_nettype none

module umbc_far_end (
  // clock
  input  wire logic       clk,
  // frame side
  output logic            rxFrameValid,
  input  wire logic       rxFrameReady,
  output logic      [7:0] rxFrameData,
  output logic            rxFrameParity,
  output logic            rxFrameStop,
  // character side
  output logic            rxCharReady,
  input  wire logic       stall
);
  assign rxCharReady = !stall;
  initial
  begin
    rxFrameValid  = 1'b0;
    rxFrameData   = 8'h00;
    rxFrameParity = 1'b0;
    rxFrameStop   = 1'b1;
  end
  // one character per frame, held until taken, then scrambled
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    int n;
    @(posedge clk);
    rxFrameValid  <= 1'b1;
    rxFrameData   <= d;
    rxFrameParity <= p;
    rxFrameStop   <= s;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rxFrameReady !== 1'b1 && n < 200);
    rxFrameValid  <= 1'b0;
    rxFrameData   <= ~d;
    rxFrameParity <= ~p;
    rxFrameStop   <= ~s;
  endtask
endmodule

`default_nettype wire

// ### test/umbc_uart_cfg_bench.sv
// testbench for the serial port mode, status and baud block
// assumes: 10 MHz clock, far-end model and checker beside the block
`timescale 1ns/1ps
`default_nettype none

module umbc_uart_cfg_bench;
  localparam logic [15:0] AM = umbc_pkg::ADDR_MODE;
  localparam logic [15:0] AS = umbc_pkg::ADDR_STATUS;
  localparam logic [15:0] AB = umbc_pkg::ADDR_BAUD;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0]  regWrData = 8'h00;
  logic [2:0]  regBitSel = 3'h0;
  logic        regWrEn = 1'b0, regBitWrEn = 1'b0, regBitVal = 1'b0, regRdEn = 1'b0;
  logic        rxBufRead = 1'b0, serialInPin = 1'b0, txSerialOut = 1'b0;
  logic        portOutVal = 1'b1, portOutOe = 1'b0, stall = 1'b0, ce = 1'b1;
  logic [7:0]  regRdData, rxCharData, rxFrameData;
  logic [1:0]  parityMode;
  logic        txPathOn, rxPathOn, charLen8, stopLen2, sampleTick, baudTick;
  logic        rxFrameValid, rxFrameReady, rxFrameParity, rxFrameStop, rxCharValid;
  logic        rxCharReady, rxDoneEvent, rxSerialIn, portInRx, serialOutPin, serialOutPinOe;
  int          badCount = 0, testsRun = 0, doneCnt = 0;

  umbc_uart_cfg u_umbc_uart_cfg (.clk, .rst_b, .ce, .regAddr, .regWrEn, .regWrData,
    .regBitWrEn, .regBitSel, .regBitVal, .regRdEn, .regRdData, .txPathOn, .rxPathOn,
    .parityMode, .charLen8, .stopLen2, .sampleTick, .baudTick, .rxFrameValid, .rxFrameReady,
    .rxFrameData, .rxFrameParity, .rxFrameStop, .rxCharValid, .rxCharReady, .rxCharData,
    .rxBufRead, .rxDoneEvent, .serialInPin, .rxSerialIn, .portInRx, .txSerialOut,
    .portOutVal, .portOutOe, .serialOutPin, .serialOutPinOe);
  umbc_far_end u_far (.clk, .rxFrameValid, .rxFrameReady, .rxFrameData, .rxFrameParity,
    .rxFrameStop, .rxCharReady, .stall);

  always #50 clk = ~clk;
  always @(posedge clk)
    if (rxDoneEvent === 1'b1)
      doneCnt <= doneCnt + 1;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    testsRun++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      badCount++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(posedge clk);
    chk(n, e, regRdData);
  endtask
  // frame, status check, optional buffer read
  task automatic frm(input logic [7:0] d, input logic p, input logic s, input logic [7:0] e,
                     input logic c);
    u_far.send(d, p, s);
    rd("status", AS, e);
    if (c)
    begin
      @(posedge clk);
      rxBufRead <= 1'b1;
      @(posedge clk);
      rxBufRead <= 1'b0;
    end
  endtask
  task automatic per(input logic [7:0] code, input int exp);
    int t;
    wr(AB, code);
    for (int j = 0; j < 2; j++)
    begin
      t = 0;
      do
      begin
        @(posedge clk);
        t++;
      end
      while (baudTick !== 1'b1 && t < 20000);
    end
    chk("baud period", 16'(exp), 16'(t));
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd("mode", AM, 8'h00);
    rd("status", AS, 8'h00);
    rd("baud", AB, 8'h00);
    wr(AM, 8'hFF);
    rd("mode", AM, 8'hFE);
    chk("settings", 16'h003F, {10'h000, txPathOn, rxPathOn, parityMode, charLen8, stopLen2});
    wr(AB, 8'hFF);
    rd("baud", AB, 8'h7F);
    wr(AS, 8'hFF);
    rd("status", AS, 8'h00);
    rd("unmapped", 16'hFFA3, 8'h00);
    wr(AM, 8'h00);
    @(posedge clk);
    regBitSel  <= 3'h6;
    regBitVal  <= 1'b1;
    regBitWrEn <= 1'b1;
    @(posedge clk);
    regBitWrEn <= 1'b0;
    rd("mode bit", AM, 8'h40);
    // a write while the clock enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(AM, 8'hC0);
    @(posedge clk);
    ce <= 1'b1;
    rd("frozen", AM, 8'h40);
  endtask
  task automatic t_pins();
    logic [7:0] m [4] = '{8'h00, 8'h80, 8'h40, 8'hC0};
    logic [3:0] e [4] = '{4'hA, 4'h6, 4'h8, 4'h4};
    for (int i = 0; i < 4; i++)
    begin
      wr(AM, m[i]);
      repeat (4) @(posedge clk);
      chk("pins", 16'(e[i]),
          {12'h000, serialOutPin, serialOutPinOe, rxSerialIn, portInRx});
    end
  endtask
  task automatic t_errors();
    int d;
    // mode changes only between frames
    for (int i = 0; i < 4; i++)
    begin
      wr(AM, 8'h48 | 8'(i << 4));
      frm(8'h03, 1'b1, 1'b1, (i == 3) ? 8'h04 : 8'h00, 1'b1);
    end
    wr(AM, 8'h60);
    frm(8'h83, 1'b1, 1'b1, 8'h00, 1'b1);
    wr(AM, 8'h4C);
    frm(8'h41, 1'b0, 1'b0, 8'h02, 1'b1);
    frm(8'h42, 1'b0, 1'b1, 8'h00, 1'b1);
    frm(8'h55, 1'b0, 1'b1, 8'h00, 1'b0);
    frm(8'h56, 1'b0, 1'b1, 8'h01, 1'b0);
    frm(8'h57, 1'b0, 1'b1, 8'h01, 1'b1);
    frm(8'h58, 1'b0, 1'b1, 8'h00, 1'b1);
    wr(AM, 8'h4E);
    d = doneCnt;
    frm(8'h41, 1'b0, 1'b0, 8'h02, 1'b1);
    chk("done", 16'(d), 16'(doneCnt));
    frm(8'h42, 1'b0, 1'b1, 8'h00, 1'b1);
    wr(AM, 8'h4C);
    frm(8'h43, 1'b0, 1'b0, 8'h02, 1'b1);
    chk("done", 16'(d + 2), 16'(doneCnt));
  endtask
  task automatic t_buffer();
    @(posedge clk);
    stall <= 1'b1;
    wr(AM, 8'h48);
    frm(8'h61, 1'b0, 1'b1, 8'h00, 1'b1);
    frm(8'h62, 1'b0, 1'b1, 8'h00, 1'b1);
    chk("frame ready", 16'h0000, {15'h0000, rxFrameReady});
    chk("head", 16'h0061, {8'h00, rxCharData});
    @(posedge clk);
    stall <= 1'b0;
    repeat (2) @(posedge clk);
    chk("second", 16'h0062, {8'h00, rxCharData});
    repeat (2) @(posedge clk);
    chk("drained", 16'h0002, {14'h0000, rxFrameReady, rxCharValid});
  endtask
  task automatic t_baud();
    int q;
    per(8'h00, 64);
    per(8'h01, 68);
    per(8'h12, 144);
    per(8'h7E, 15360);
    wr(AB, 8'h0F);
    q = 0;
    repeat (300) @(posedge clk)
      if (sampleTick === 1'b1)
        q++;
    chk("prohibited", 16'h0000, 16'(q));
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_pins();
    t_errors();
    t_buffer();
    t_baud();
    giveVerdict();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    badCount++;
    giveVerdict();
  end
endmodule

bind umbc_uart_cfg umbc_uart_cfg_props u_props (.clk, .rst_b, .regAddr, .regRdEn, .regRdData,
  .txPathOn, .rxPathOn, .sampleTick, .baudTick, .rxFrameValid, .rxFrameReady, .rxDoneEvent,
  .rxSerialIn, .portOutOe, .serialOutPinOe);

`default_nettype wire

// ### test/umbc_uart_cfg_props.sv
// checker for the serial port mode, status and baud block
// assumes: bound to umbc_uart_cfg, ce low only while the inputs stand still
`timescale 1ns/1ps
`default_nettype none

module umbc_uart_cfg_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register port
  input wire logic [15:0] regAddr,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData,
  // settings and timing
  input wire logic        txPathOn,
  input wire logic        rxPathOn,
  input wire logic        sampleTick,
  input wire logic        baudTick,
  // frames and pins
  input wire logic        rxFrameValid,
  input wire logic        rxFrameReady,
  input wire logic        rxDoneEvent,
  input wire logic        rxSerialIn,
  input wire logic        portOutOe,
  input wire logic        serialOutPinOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_rd(a);
    regRdEn && regAddr == a;
  endsequence
  sequence s_idle;
    !txPathOn && !rxPathOn;
  endsequence

  a_mode_bit0: assert property (s_rd(umbc_pkg::ADDR_MODE) |=> !regRdData[0])
    else $error("mode bit 0 read as one");
  a_stat_high: assert property (s_rd(umbc_pkg::ADDR_STATUS) |=> regRdData[7:3] == 5'h00)
    else $error("status upper bits not zero");
  a_baud_bit7: assert property (s_rd(umbc_pkg::ADDR_BAUD) |=> !regRdData[7])
    else $error("baud bit 7 read as one");
  a_tx_pin: assert property (txPathOn && $past(txPathOn) |-> serialOutPinOe)
    else $error("transmit pin not driven");
  a_port_oe: assert property (!txPathOn && !$past(txPathOn) |-> serialOutPinOe == $past(portOutOe))
    else $error("port enable not passed");
  a_rx_port: assert property (!rxPathOn && !$past(rxPathOn) |-> rxSerialIn)
    else $error("receive line not idle");
  a_done_cause: assert property (rxDoneEvent |-> $past(rxFrameValid && rxFrameReady))
    else $error("done without frame");
  a_tick_gap: assert property (sampleTick |=> !sampleTick [*8])
    else $error("sample ticks too close");
  a_tick_stop: assert property (s_idle ##1 s_idle |-> !sampleTick && !baudTick)
    else $error("ticks while disabled");
endmodule

`default_nettype wire
